// ===== logic/fspa_latch_mem.sv
// Write latch storage with registered read port
`timescale 1ns/1ps
module fspa_latch_mem #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 8,
    parameter int AW    = 3
) (
    input  wire logic             clk,
    input  wire logic             ce,
    input  wire logic             we,
    input  wire logic [AW-1:0]    waddr,
    input  wire logic [WIDTH-1:0] wdata,
    input  wire logic [AW-1:0]    raddr,
    output logic      [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (ce) begin
            if (we) begin
                mem[waddr] <= wdata;
            end
            rdata <= mem[raddr];
        end
    end
endmodule : fspa_latch_mem

// ===== logic/fspa_pkg.sv
// Constants and types for the flash self-programming access block
// Overview of operation
// R1: Config select addresses the top address region
// R2: Bad config read clears both data halves
// R3: User IDs read/write; ID and config read-only
// R4: Latch-only write just loads a write latch
// R5: Final unlocked write loads latch, programs block
// R6: Software writes 55h, AAh, then sets write
// R7: Write ignores two slots, stalls, then resumes
// R8: Read executes next slot, ignores the following
// R9: Data low holds low eight word bits
// R10: Data high holds upper six bits, top zero
// R11: Address low supplies address bits 7-0
// R12: Address high supplies bits 14-8, bit7 zero
// R13: Config read: select, low address, clear high
// R14: Program write needs program select and enable
// R15: Software masks interrupts around unlock sequences
// R16: Block starts aligned; last latch at 0x07
// R17: Row rewrite: read, edit, erase, reprogram
// R18: Software may verify each write by readback
// R19: Program completion resets all latches to 3FFF
// R20: Hardware clears write bit after operation
// R21: Writes to read-only config words are dropped
package fspa_pkg;
    localparam int APB_AW = 8;
    localparam logic [7:0] OFF_DATA_LOW  = 8'h00;
    localparam logic [7:0] OFF_DATA_HIGH = 8'h04;
    localparam logic [7:0] OFF_ADDR_LOW  = 8'h08;
    localparam logic [7:0] OFF_ADDR_HIGH = 8'h0c;
    localparam logic [7:0] OFF_NV_CTRL   = 8'h10;
    localparam logic [7:0] OFF_UNLOCK    = 8'h14;
    localparam int BIT_PGM  = 7;
    localparam int BIT_CONFIG_SPACE_SELECT = 6;
    localparam int BIT_LATCH_ONLY = 5;
    localparam int BIT_WRITE_ENABLE_BIT = 2;
    localparam int BIT_WR   = 1;
    localparam int BIT_RD   = 0;
    localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
    localparam logic [7:0] UNLOCK_KEY2 = 8'haa;
    localparam logic [1:0] UNLOCK_IDLE  = 2'h0;
    localparam logic [1:0] UNLOCK_HALF  = 2'h1;
    localparam logic [1:0] UNLOCK_ARMED = 2'h2;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [13:0] LATCH_ERASED = 14'h3fff;
    localparam int LATCH_WORDS = 8;
    localparam int LATCH_AW    = 3;
    localparam int WORD_W      = 14;
    localparam logic [2:0] LATCH_LAST = 3'h7;
    localparam logic [3:0] PROG_LAST  = 4'h8;
    localparam logic [3:0] PROG_START = 4'h9;
    localparam logic [1:0] IGN_WR = 2'h2;
    localparam logic [1:0] IGN_RD = 2'h1;
    localparam logic [15:0] CFG_UID_FIRST  = 16'h8000;
    localparam logic [15:0] CFG_UID_LAST   = 16'h8003;
    localparam logic [15:0] CFG_DEV_ID     = 16'h8006;
    localparam logic [15:0] CFG_WORD_FIRST = 16'h8007;
    localparam logic [15:0] CFG_WORD_LAST  = 16'h8008;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_LOAD  = 3'b001,
        ST_PROG  = 3'b011,
        ST_WAIT  = 3'b010,
        ST_CLEAR = 3'b110,
        ST_READ  = 3'b100
    } fspa_state_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [13:0] wdata;
        logic        load;
        logic        start;
        logic        rd;
    } fspa_flash_req_t;

    typedef struct packed {
        logic [13:0] rdata;
        logic        done;
    } fspa_flash_rsp_t;

    function automatic logic [15:0] fspa_word_addr(input logic cfg, input logic [6:0] ah,
                                                   input logic [7:0] al);
        return {cfg, ah, al};
    endfunction : fspa_word_addr

    function automatic logic fspa_cfg_writable(input logic [15:0] a);
        return (a >= CFG_UID_FIRST) && (a <= CFG_UID_LAST);
    endfunction : fspa_cfg_writable

    function automatic logic fspa_cfg_readable(input logic [15:0] a);
        return fspa_cfg_writable(a) || (a == CFG_DEV_ID)
            || ((a >= CFG_WORD_FIRST) && (a <= CFG_WORD_LAST));
    endfunction : fspa_cfg_readable
endpackage : fspa_pkg

// ===== logic/fspa_top.sv
// Flash self-programming access block with APB register port
`timescale 1ns/1ps
module fspa_top (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        ce,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [fspa_pkg::APB_AW-1:0] paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic                        instr_slot,
    output logic                             core_ignore,
    output logic                             core_stall,
    output fspa_pkg::fspa_flash_req_t        flash_req,
    input  wire fspa_pkg::fspa_flash_rsp_t   flash_rsp
);
    import fspa_pkg::*;

    logic [7:0]        data_low;
    logic [5:0]        data_high;
    logic [7:0]        address_low;
    logic [6:0]        address_high;
    logic              pgm_sel;
    logic              cfg_sel;
    logic              latch_only;
    logic              write_enable_bit;
    logic              wr_bit;
    logic              rd_bit;
    logic [1:0]        unlock_stage;
    fspa_state_t       state;
    logic [3:0]        cnt;
    logic [3:0]        cnt_m1;
    logic [15:0]       blk_base;
    logic              exec_left;
    logic [1:0]        ign_left;
    logic              next_exec;
    logic [1:0]        next_ign;
    logic              apb_acc;
    logic              apb_wr;
    logic              nv_wr;
    logic              wr_try;
    logic              wr_ok;
    logic              wr_go;
    logic              rd_go;
    logic              rd_bad;
    logic              prog_busy;
    logic [15:0]       cmd_addr;
    logic              mem_we;
    logic [2:0]        mem_waddr;
    logic [13:0]       mem_wdata;
    logic [13:0]       mem_rdata;
    logic [31:0]       read_mux;
    logic              mapped;

    // Bus phases
    assign apb_acc = psel && penable && !pready;
    assign apb_wr  = psel && penable && pready && pwrite;
    assign nv_wr   = apb_wr && (paddr == OFF_NV_CTRL);

    // Command decode
    assign cmd_addr = fspa_word_addr(pwdata[BIT_CONFIG_SPACE_SELECT], address_high, address_low); // R1
    assign wr_try = nv_wr && pwdata[BIT_WR] && pwdata[BIT_WRITE_ENABLE_BIT]
                 && (unlock_stage == UNLOCK_ARMED) && (state == ST_IDLE) && !wr_bit; // R6
    assign wr_ok = pwdata[BIT_CONFIG_SPACE_SELECT] ? fspa_cfg_writable(cmd_addr) : pwdata[BIT_PGM]; // R21
    assign wr_go = wr_try && wr_ok; // R3
    assign rd_go = nv_wr && pwdata[BIT_RD] && (state == ST_IDLE) && !rd_bit && !wr_try;
    assign rd_bad = rd_go && pwdata[BIT_CONFIG_SPACE_SELECT] && !fspa_cfg_readable(cmd_addr); // R3
    assign prog_busy = wr_bit && ((state == ST_PROG) || (state == ST_WAIT)
                                  || (state == ST_CLEAR));
    assign cnt_m1 = cnt - 4'h1;

    // Latch memory ports
    assign mem_we    = (state == ST_LOAD) || (state == ST_CLEAR);
    assign mem_waddr = (state == ST_LOAD) ? address_low[2:0] : cnt[2:0];
    assign mem_wdata = (state == ST_LOAD) ? {data_high, data_low} : LATCH_ERASED; // R19

    fspa_latch_mem #(
        .WIDTH (WORD_W),
        .DEPTH (LATCH_WORDS),
        .AW    (LATCH_AW)
    ) u_latch (
        .clk   (pclk),
        .ce    (ce),
        .we    (mem_we),
        .waddr (mem_waddr),
        .wdata (mem_wdata),
        .raddr (cnt[2:0]),
        .rdata (mem_rdata)
    );

    // Register read view
    always_comb begin
        read_mux = '0;
        mapped = 1'b1;
        case (paddr)
            OFF_DATA_LOW: begin
                read_mux[7:0] = data_low; // R9
            end
            OFF_DATA_HIGH: begin
                read_mux[5:0] = data_high; // R10
            end
            OFF_ADDR_LOW: begin
                read_mux[7:0] = address_low; // R11
            end
            OFF_ADDR_HIGH: begin
                read_mux[6:0] = address_high; // R12
            end
            OFF_NV_CTRL: begin
                read_mux[BIT_PGM]  = pgm_sel;
                read_mux[BIT_CONFIG_SPACE_SELECT] = cfg_sel;
                read_mux[BIT_LATCH_ONLY] = latch_only;
                read_mux[BIT_WRITE_ENABLE_BIT] = write_enable_bit;
                read_mux[BIT_WR]   = wr_bit;
                read_mux[BIT_RD]   = rd_bit;
            end
            OFF_UNLOCK: begin
                read_mux = '0;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // APB answer, one wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else if (ce) begin
            pready <= apb_acc;
            if (apb_acc) begin
                pslverr <= !mapped;
                prdata  <= pwrite ? '0 : read_mux;
            end
        end
    end

    // Unlock sequence tracker
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unlock_stage <= UNLOCK_IDLE;
        end else if (ce && apb_wr) begin
            if (paddr != OFF_UNLOCK) begin
                unlock_stage <= UNLOCK_IDLE; // R6
            end else if (pwdata[7:0] == UNLOCK_KEY1) begin
                unlock_stage <= UNLOCK_HALF;
            end else if ((unlock_stage == UNLOCK_HALF) && (pwdata[7:0] == UNLOCK_KEY2)) begin
                unlock_stage <= UNLOCK_ARMED;
            end else begin
                unlock_stage <= UNLOCK_IDLE;
            end
        end
    end

    // Control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pgm_sel    <= 1'b0;
            cfg_sel    <= 1'b0;
            latch_only <= 1'b0;
            write_enable_bit       <= 1'b0;
            wr_bit     <= 1'b0;
            rd_bit     <= 1'b0;
        end else if (ce) begin
            if ((state == ST_LOAD) && latch_only) begin
                wr_bit <= 1'b0; // R20
            end
            if ((state == ST_CLEAR) && (cnt[2:0] == LATCH_LAST)) begin
                wr_bit <= 1'b0; // R20
            end
            if ((state == ST_READ) && cnt[0]) begin
                rd_bit <= 1'b0;
            end
            if (nv_wr) begin
                pgm_sel    <= pwdata[BIT_PGM];
                cfg_sel    <= pwdata[BIT_CONFIG_SPACE_SELECT];
                latch_only <= pwdata[BIT_LATCH_ONLY];
                write_enable_bit       <= pwdata[BIT_WRITE_ENABLE_BIT];
                if (wr_go) begin
                    wr_bit <= 1'b1;
                end
                if (rd_go && !rd_bad) begin
                    rd_bit <= 1'b1;
                end
            end
        end
    end

    // Data and address registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_low     <= RESET_BYTE;
            data_high    <= RESET_BYTE[5:0];
            address_low  <= RESET_BYTE;
            address_high <= RESET_BYTE[6:0];
        end else if (ce) begin
            if (apb_wr) begin
                case (paddr)
                    OFF_DATA_LOW: begin
                        data_low <= pwdata[7:0];
                    end
                    OFF_DATA_HIGH: begin
                        data_high <= pwdata[5:0];
                    end
                    OFF_ADDR_LOW: begin
                        address_low <= pwdata[7:0];
                    end
                    OFF_ADDR_HIGH: begin
                        address_high <= pwdata[6:0];
                    end
                    default: begin
                    end
                endcase
            end
            if (rd_bad) begin
                data_low  <= '0; // R2
                data_high <= '0; // R2
            end
            if ((state == ST_READ) && cnt[0]) begin
                data_low  <= flash_rsp.rdata[7:0]; // R8 R9
                data_high <= flash_rsp.rdata[13:8]; // R10
            end
        end
    end

    // Operation sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state     <= ST_CLEAR;
            cnt       <= '0;
            blk_base  <= '0;
            flash_req <= '0;
        end else if (ce) begin
            flash_req.load  <= 1'b0;
            flash_req.start <= 1'b0;
            flash_req.rd    <= 1'b0;
            unique case (state)
                ST_IDLE: begin
                    cnt <= '0;
                    if (rd_go && !rd_bad) begin
                        flash_req.rd   <= 1'b1;
                        flash_req.addr <= cmd_addr; // R1
                        state          <= ST_READ;
                    end else if (wr_go) begin
                        blk_base <= {cmd_addr[15:3], 3'h0};
                        state    <= ST_LOAD;
                    end
                end
                ST_READ: begin
                    cnt <= cnt + 4'h1;
                    if (cnt[0]) begin
                        state <= ST_IDLE;
                    end
                end
                ST_LOAD: begin
                    state <= latch_only ? ST_IDLE : ST_PROG; // R4 R5
                end
                ST_PROG: begin
                    cnt <= cnt + 4'h1;
                    if ((cnt != 4'h0) && (cnt <= PROG_LAST)) begin
                        flash_req.load  <= !blk_base[15] // R5 R21
                            || fspa_cfg_writable(blk_base | {13'h0, cnt_m1[2:0]});
                        flash_req.wdata <= mem_rdata;
                        flash_req.addr  <= blk_base | {13'h0, cnt_m1[2:0]};
                    end
                    if (cnt == PROG_START) begin
                        flash_req.start <= 1'b1; // R5
                        flash_req.addr  <= blk_base;
                        state           <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    cnt <= '0;
                    if (flash_rsp.done) begin
                        state <= ST_CLEAR; // R19
                    end
                end
                ST_CLEAR: begin
                    cnt <= cnt + 4'h1;
                    if (cnt[2:0] == LATCH_LAST) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Instruction slot bookkeeping
    always_comb begin
        next_exec = exec_left;
        next_ign  = ign_left;
        if (rd_go) begin
            next_exec = 1'b1; // R8
            next_ign  = IGN_RD;
        end else if (wr_go) begin
            next_exec = 1'b0; // R7
            next_ign  = IGN_WR;
        end else if (instr_slot) begin
            if (exec_left) begin
                next_exec = 1'b0;
            end else if (ign_left != 2'h0) begin
                next_ign = ign_left - 2'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            exec_left   <= 1'b0;
            ign_left    <= 2'h0;
            core_ignore <= 1'b0;
            core_stall  <= 1'b0;
        end else if (ce) begin
            exec_left   <= next_exec;
            ign_left    <= next_ign;
            core_ignore <= !next_exec && (next_ign != 2'h0); // R7 R8
            core_stall  <= prog_busy && (next_ign == 2'h0); // R7
        end
    end

    // Checks
    default clocking chk_clk @(posedge pclk);
    endclocking
    default disable iff (!presetn || !ce);

    dath_zero_a: assert property ( // R10
        (apb_acc && !pwrite && (paddr == OFF_DATA_HIGH)) |=> (prdata[31:6] == 26'h0))
        else $error("data high upper bits not zero");

    adrh_zero_a: assert property ( // R12
        (apb_acc && !pwrite && (paddr == OFF_ADDR_HIGH)) |=> (prdata[31:7] == 25'h0))
        else $error("address high bit 7 not zero");

    bad_read_clear_a: assert property ( // R2
        rd_bad |=> (data_low == 8'h00) && (data_high == 6'h00) && (state == ST_IDLE))
        else $error("bad config read did not clear data");

    cfg_region_a: assert property ( // R1
        flash_req.rd |-> (flash_req.addr[15] == cfg_sel)
                      && (flash_req.addr[14:0] == {address_high, address_low}))
        else $error("read address does not follow selects");

    ro_write_drop_a: assert property ( // R21
        (wr_try && !wr_ok) |=> (state == ST_IDLE) && !wr_bit)
        else $error("write to read-only location accepted");

    latch_only_a: assert property ( // R4
        (wr_go && pwdata[BIT_LATCH_ONLY]) |=> (state == ST_LOAD) ##1 (state == ST_IDLE)
                                         && !wr_bit && !flash_req.start && !flash_req.load)
        else $error("latch-only write went beyond latch");

    prog_start_a: assert property ( // R5
        (wr_go && !pwdata[BIT_LATCH_ONLY]) |-> ##12 (flash_req.start && (state == ST_WAIT)))
        else $error("program did not start in time");

    slot_ignore_a: assert property ( // R7
        wr_go |=> core_ignore && !core_stall)
        else $error("write did not ignore next slot");

    read_slot_a: assert property ( // R8
        (rd_go && !rd_bad) |=> !core_ignore ##2 (data_low == $past(flash_rsp.rdata[7:0])))
        else $error("read slot or data wrong");

    latch_reset_a: assert property ( // R19
        ((state == ST_WAIT) && flash_rsp.done) |=> (mem_we && (mem_wdata == LATCH_ERASED)) [*8]
                                                ##1 (state == ST_IDLE))
        else $error("latches not reset after program");

    wr_clear_a: assert property ( // R20
        ((state == ST_WAIT) && flash_rsp.done) |-> ##9 !wr_bit)
        else $error("write bit not cleared by hardware");

    latch_load_c: cover property (wr_go && pwdata[BIT_LATCH_ONLY]);
    block_prog_c: cover property ((state == ST_WAIT) && flash_rsp.done);
    bad_read_c: cover property (rd_bad);
    good_read_c: cover property (rd_go && !rd_bad && pwdata[BIT_CONFIG_SPACE_SELECT]);
endmodule : fspa_top

// ===== tb/fspa_flash_model.sv
// Behavioural program Flash array answering the block's Flash request port
`timescale 1ns/1ps
module fspa_flash_model #(
    parameter int          PROG_CYCLES = 40,
    parameter logic [13:0] DEV_ID_VAL  = 14'h1a5c,
    parameter logic [13:0] CFG1_VAL    = 14'h2f4b
) (
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    input  wire fspa_pkg::fspa_flash_req_t req,
    output fspa_pkg::fspa_flash_rsp_t      rsp
);
    import fspa_pkg::*;
    logic [13:0] mem [logic [15:0]];
    logic [13:0] pend [logic [15:0]];
    int          busy_cnt;

    // Identity value is arbitrary
    initial begin
        mem[16'h8006] = DEV_ID_VAL;
        mem[16'h8007] = CFG1_VAL;
    end

    // Read data stands one cycle, then the bus shows a changing pattern
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp      <= '0;
            busy_cnt <= 0;
        end else begin
            rsp.done  <= 1'b0;
            rsp.rdata <= ~rsp.rdata;
            if (req.rd) begin
                rsp.rdata <= mem.exists(req.addr) ? mem[req.addr] : 14'h0000;
            end
            if (req.load) begin
                pend[req.addr] = req.wdata;
            end
            if (req.start) begin
                busy_cnt <= PROG_CYCLES;
            end else if (busy_cnt > 0) begin
                busy_cnt <= busy_cnt - 1;
            end
            if (busy_cnt == 1) begin
                foreach (pend[a]) begin
                    mem[a] = pend[a];
                end
                pend.delete();
                rsp.done <= 1'b1;
            end
        end
    end
endmodule : fspa_flash_model

// ===== tb/fspa_top_tb.sv
// Self-checking testbench for the flash self-programming access block
`timescale 1ns/1ps
module fspa_top_tb;
    import fspa_pkg::*;
    localparam logic [13:0] DEV_ID = 14'h1a5c;
    localparam logic [13:0] CFG1   = 14'h2f4b;
    logic            pclk, presetn, ce, psel, penable, pwrite, instr_slot;
    logic            pready, pslverr, core_ignore, core_stall, e;
    logic [7:0]      paddr;
    logic [31:0]     pwdata, prdata, q;
    fspa_flash_req_t flash_req;
    fspa_flash_rsp_t flash_rsp;
    int              mismatches = 0, samples_checked = 0, cycles = 0;
    int              ign_cnt = 0, stl_cnt = 0, i0, s0;

    fspa_top fspa_top_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .instr_slot(instr_slot),
        .core_ignore(core_ignore), .core_stall(core_stall), .flash_req(flash_req),
        .flash_rsp(flash_rsp));
    fspa_flash_model #(.DEV_ID_VAL(DEV_ID), .CFG1_VAL(CFG1)) fspa_flash_model_i (
        .clk(pclk), .rst_n(presetn), .req(flash_req), .rsp(flash_rsp));

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // Cycle ceiling and counts of ignored and stalled slots
    always @(posedge pclk) begin
        cycles  <= cycles + 1;
        ign_cnt <= ign_cnt + int'(core_ignore === 1'b1);
        stl_cnt <= stl_cnt + int'(core_stall === 1'b1);
        if (cycles == 40000) begin
            mismatches++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask : rd_chk

    task automatic wait_idle();
        for (int n = 0; n < 200; n++) begin
            apb(1'b0, OFF_NV_CTRL, 32'h0);
            if (q[1:0] === 2'b00) return;
        end
        mismatches++;
    endtask : wait_idle

    task automatic cmd(input logic [7:0] ctrl);
        apb(1'b1, OFF_UNLOCK, 32'h55);
        apb(1'b1, OFF_UNLOCK, 32'haa);
        apb(1'b1, OFF_NV_CTRL, {24'h0, ctrl});
    endtask : cmd

    task automatic set_word(input logic [14:0] a, input logic [13:0] w);
        apb(1'b1, OFF_ADDR_LOW, {24'h0, a[7:0]});
        apb(1'b1, OFF_ADDR_HIGH, {25'h0, a[14:8]});
        apb(1'b1, OFF_DATA_LOW, {24'h0, w[7:0]});
        apb(1'b1, OFF_DATA_HIGH, {26'h0, w[13:8]});
    endtask : set_word

    task automatic read_word(input logic [14:0] a, input logic cfg, input logic [13:0] exp);
        apb(1'b1, OFF_ADDR_LOW, {24'h0, a[7:0]});
        apb(1'b1, OFF_ADDR_HIGH, {25'h0, a[14:8]});
        i0 = ign_cnt;
        apb(1'b1, OFF_NV_CTRL, {24'h0, cfg ? 8'h41 : 8'h81});
        wait_idle();
        chk(ign_cnt - i0, 1);
        rd_chk(OFF_DATA_LOW, {24'h0, exp[7:0]});
        rd_chk(OFF_DATA_HIGH, {24'h0, 2'b00, exp[13:8]});
    endtask : read_word

    function automatic logic [13:0] pat(input int k);
        return 14'(16'h1a00 + k * 16'h0135);
    endfunction : pat

    initial begin
        presetn = 1'b0; ce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; instr_slot = 1'b1;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (12) @(posedge pclk);
        for (int k = 0; k < 6; k++) rd_chk(8'(4 * k), 32'h0);
        apb(1'b1, OFF_DATA_LOW, 32'hff);
        apb(1'b1, OFF_DATA_HIGH, 32'hff);
        apb(1'b1, OFF_ADDR_LOW, 32'hff);
        apb(1'b1, OFF_ADDR_HIGH, 32'hff);
        rd_chk(OFF_DATA_LOW, 32'hff);
        rd_chk(OFF_DATA_HIGH, 32'h3f);
        rd_chk(OFF_ADDR_LOW, 32'hff);
        rd_chk(OFF_ADDR_HIGH, 32'h7f);
        apb(1'b0, 8'h18, 32'h0);
        chk({e, q[30:0]}, 32'h80000000);
        // Command without unlock, and with a broken unlock, is dropped
        apb(1'b1, OFF_NV_CTRL, 32'h86);
        rd_chk(OFF_NV_CTRL, 32'h84);
        apb(1'b1, OFF_UNLOCK, 32'h55);
        apb(1'b1, OFF_DATA_LOW, 32'h11);
        apb(1'b1, OFF_UNLOCK, 32'haa);
        apb(1'b1, OFF_NV_CTRL, 32'h86);
        rd_chk(OFF_NV_CTRL, 32'h84);
        // Eight-word block, seven latch-only loads then the programming load;
        // the second pass rewrites the row from its read-back image, one word edited
        for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < 8; k++) begin
                set_word(15'h0010 + 15'(k), pat((p == 1 && k == 3) ? 40 : k));
                i0 = ign_cnt;
                s0 = stl_cnt;
                cmd(k == 7 ? 8'h86 : 8'ha6);
                wait_idle();
                chk(ign_cnt - i0, 2);
                chk(32'(stl_cnt > s0), 32'(k == 7));
            end
            rd_chk(OFF_NV_CTRL, 32'h84);
            for (int k = 0; k < 8; k++) begin
                read_word(15'h0010 + 15'(k), 1'b0, pat((p == 1 && k == 3) ? 40 : k));
            end
        end
        // Only the last latch loaded: the rest of the block holds the erased value
        set_word(15'h0027, 14'h0abc);
        cmd(8'h86);
        wait_idle();
        read_word(15'h0020, 1'b0, 14'h3fff);
        read_word(15'h0027, 1'b0, 14'h0abc);
        // Configuration space
        read_word(15'h0006, 1'b1, DEV_ID);
        apb(1'b1, OFF_DATA_LOW, 32'h5a);
        read_word(15'h0004, 1'b1, 14'h0000);
        set_word(15'h0007, 14'h0123);
        cmd(8'h46);
        rd_chk(OFF_NV_CTRL, 32'h44);
        read_word(15'h0007, 1'b1, CFG1);
        set_word(15'h0001, 14'h1357);
        cmd(8'h46);
        wait_idle();
        read_word(15'h0001, 1'b1, 14'h1357);
        read_word(15'h0007, 1'b1, CFG1);
        stop_test();
    end
endmodule : fspa_top_tb
